/* File: src/sbc_pkg.sv */
package sbc_pkg;
    localparam int CLK_HZ      = 10_000_000;
    // fault restart pause
    localparam int RESTART_MS  = 1000;
    localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
    // soft-start ramp step times, charge 3.8 uA vs discharge 36 uA
    localparam int RAMP_UP_CYC = 360;
    localparam int RAMP_DN_CYC = RAMP_UP_CYC * 38 / 360;
    localparam int FST_BASE_EXP = 16;
    localparam int MIN_STEP_CYC = 100;

    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] SPEED_OFS  = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    localparam int CTRL_PROT   = 0;
    localparam int CTRL_120    = 1;
    localparam int CTRL_LEAD   = 2;
    localparam int CTRL_PWM_RATE_SELECT   = 4;
    localparam int CTRL_FST_LO = 5;
    localparam int CTRL_FST_HI = 6;
    localparam int CTRL_REV    = 7;
    localparam logic [7:0] CTRL_RST  = 8'h03;
    // code of a 1 V speed command
    localparam logic [6:0] STOP_CODE = 7'h1a;

    typedef enum logic [2:0] {M_IDLE, M_ALIGN, M_FORCED, M_RUN, M_FAULT} sbc_mode_t;

    typedef struct packed {
        logic [2:0] hs;
        logic [2:0] ls;
    } sbc_bridge_t;

    typedef struct packed {
        sbc_mode_t   mode;
        logic [7:0]  ctrl;
        logic [6:0]  speed;
        logic [6:0]  ramp;
        logic [15:0] rdiv;
        logic [7:0]  pcnt;
        logic        raw;
        logic        pwm;
        logic        pos_s;
        logic [2:0]  step;
        logic [19:0] fcnt;
        logic [20:0] itv;
        logic [20:0] dly;
        logic        pend;
        logic        ovl;
        logic [31:0] rcnt;
        logic        flt_fast;
        logic        flt_slow;
        sbc_bridge_t br;
        logic        posout;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sbc_st_t;
endpackage

/* File: src/sbc_core.sv */
// Overview of operation
// - at start hold rotor by DC excitation, then begin forced commutation
// - alignment ends when alignment node falls below half reference
// - alignment and forced modes take PWM duty from soft-start ramp
// - enter sensorless mode once rotation beats forced commutation rate
// - sensorless mode takes PWM duty from speed command
// - forced rate is clock over six times 2^16..2^19 by select lines
// - PWM period is 128 clocks if rate select high, else 256
// - 7-bit speed command code sets PWM duty
// - command below 1 V means stopped; ramp collapses to zero at once
// - ramp follows command, falling about ten times faster than rising
// - fault protection on when protection select high, off when low
// - on fault turn all switches off, restart after one second, repeat
// - fault when commutation too fast or rotation below forced rate
// - position sampled on each falling edge of internal PWM
// - zero lead in forced mode, selected lead angle in sensorless mode
// - overlap select high gives 120 degree, low gives overlap commutation
// - overlap spans zero-cross to commutation instant, length follows lead
// - overcurrent sense stops all PWM outputs immediately
// - position output is majority of three phase polarities
`timescale 1ns/100ps
module sbc_core #(
    parameter int               RESTART_CYC  = sbc_pkg::RESTART_CYC,
    parameter int               RAMP_UP_CYC  = sbc_pkg::RAMP_UP_CYC,
    parameter int               RAMP_DN_CYC  = sbc_pkg::RAMP_DN_CYC,
    parameter int               MIN_STEP_CYC = sbc_pkg::MIN_STEP_CYC,
    parameter logic [3:0][2:0]  LEAD_EIGHTHS = {3'h4, 3'h2, 3'h1, 3'h0}
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [7:0]    paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          align_below_half,
    input  wire logic          position_sense_pos,
    input  wire logic          position_sense_neg,
    input  wire logic [2:0]    phase_polarity,
    input  wire logic          overcurrent_sense,
    output sbc_pkg::sbc_bridge_t bridge,
    output logic               pwm_out,
    output logic               position_out
);
    localparam sbc_pkg::sbc_st_t ST_RST = '{
        mode: sbc_pkg::M_IDLE, ctrl: sbc_pkg::CTRL_RST, default: '0};

    generate
        if (RESTART_CYC < 1 || RAMP_UP_CYC < 1 || RAMP_DN_CYC < 1
            || RAMP_UP_CYC > 65535 || RAMP_DN_CYC > 65535
            || MIN_STEP_CYC < 1 || MIN_STEP_CYC > 65535) begin : g_bad_cnt
            $error("sbc_core: count parameter out of range");
        end
        for (genvar i = 0; i < 4; i++) begin : g_lead_chk
            if (LEAD_EIGHTHS[i] > 3'h4) begin : g_bad
                $error("sbc_core: lead angle beyond 30 degrees");
            end
        end
    endgenerate

    sbc_pkg::sbc_st_t s;
    sbc_pkg::sbc_st_t n;

    function automatic logic [2:0] step_next(input logic [2:0] st, input logic rev);
        if (rev)
            return (st == 3'h0) ? 3'h5 : st - 3'h1;
        return (st == 3'h5) ? 3'h0 : st + 3'h1;
    endfunction

    // one phase high, one phase low per step
    function automatic sbc_pkg::sbc_bridge_t step_map(input logic [2:0] st);
        sbc_pkg::sbc_bridge_t b;
        unique case (st)
            3'h0:    b = '{hs: 3'h1, ls: 3'h2};
            3'h1:    b = '{hs: 3'h1, ls: 3'h4};
            3'h2:    b = '{hs: 3'h2, ls: 3'h4};
            3'h3:    b = '{hs: 3'h2, ls: 3'h1};
            3'h4:    b = '{hs: 3'h4, ls: 3'h1};
            3'h5:    b = '{hs: 3'h4, ls: 3'h2};
            default: b = '0;
        endcase
        return b;
    endfunction

    always_comb begin
        logic        stop;
        logic        prot;
        logic        rev;
        logic [1:0]  fsel;
        logic [20:0] flen;
        logic [6:0]  duty;
        logic [7:0]  cmp;
        logic [7:0]  pmax;
        logic        zc;
        logic [2:0]  lead;
        logic [23:0] prod;
        logic        active;
        sbc_pkg::sbc_bridge_t b;
        stop   = 1'b0;
        prot   = 1'b0;
        rev    = 1'b0;
        fsel   = '0;
        flen   = '0;
        duty   = '0;
        cmp    = '0;
        pmax   = '0;
        zc     = 1'b0;
        lead   = '0;
        prod   = '0;
        active = 1'b0;
        b      = '0;
        n      = s;

        // register access, zero wait states
        n.pready  = psel & ~penable;
        n.pslverr = 1'b0;
        n.prdata  = '0;
        if (psel && !penable) begin
            case (paddr)
                sbc_pkg::CTRL_OFS:   n.prdata = {24'h0, s.ctrl};
                sbc_pkg::SPEED_OFS:  n.prdata = {25'h0, s.speed};
                sbc_pkg::STATUS_OFS: n.prdata = {13'h0, s.flt_slow, s.flt_fast, s.pos_s,
                                                 1'b0, s.ramp, 2'h0, s.step, s.mode};
                default:             n.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s.pready && pwrite) begin
            case (paddr)
                sbc_pkg::CTRL_OFS:  n.ctrl = pwdata[7:0];
                sbc_pkg::SPEED_OFS: n.speed = pwdata[6:0];
                default:            n.ctrl = s.ctrl;
            endcase
        end

        prot = s.ctrl[sbc_pkg::CTRL_PROT];
        rev  = s.ctrl[sbc_pkg::CTRL_REV];
        stop = s.speed < sbc_pkg::STOP_CODE;
        // forced step length 2^k clocks, six steps per turn
        fsel = {s.ctrl[sbc_pkg::CTRL_FST_HI], s.ctrl[sbc_pkg::CTRL_FST_LO]};
        flen = 21'h1 << (sbc_pkg::FST_BASE_EXP + 3 - int'(fsel));
        lead = LEAD_EIGHTHS[s.ctrl[sbc_pkg::CTRL_LEAD +: 2]];

        if (stop) begin
            n.ramp = '0;
            n.rdiv = '0;
        end else if (s.ramp == s.speed) begin
            n.rdiv = '0;
        end else if (s.ramp < s.speed) begin
            n.rdiv = s.rdiv + 16'h1;
            if (s.rdiv >= 16'(RAMP_UP_CYC - 1)) begin
                n.rdiv = '0;
                n.ramp = s.ramp + 7'h1;
            end
        end else begin
            n.rdiv = s.rdiv + 16'h1;
            if (s.rdiv >= 16'(RAMP_DN_CYC - 1)) begin
                n.rdiv = '0;
                n.ramp = s.ramp - 7'h1;
            end
        end

        pmax   = s.ctrl[sbc_pkg::CTRL_PWM_RATE_SELECT] ? 8'h7f : 8'hff;
        n.pcnt = (s.pcnt >= pmax) ? 8'h0 : s.pcnt + 8'h1;
        // duty from ramp, from command in sensorless mode
        duty   = (s.mode == sbc_pkg::M_RUN) ? s.speed : s.ramp;
        cmp    = s.ctrl[sbc_pkg::CTRL_PWM_RATE_SELECT] ? {1'b0, duty} : {duty, 1'b0};
        n.raw  = s.pcnt < cmp;

        if (s.raw && !n.raw) begin
            n.pos_s = position_sense_pos & ~position_sense_neg;
        end
        zc = (s.raw && !n.raw) && (n.pos_s != s.pos_s);

        n.itv = (s.itv == 21'h1fffff) ? s.itv : s.itv + 21'h1;
        if (zc) begin
            n.itv = '0;
        end

        unique case (s.mode)
            sbc_pkg::M_IDLE: begin
                n.step = '0;
                n.pend = 1'b0;
                n.ovl  = 1'b0;
                if (!stop) begin
                    n.mode = sbc_pkg::M_ALIGN;
                end
            end
            sbc_pkg::M_ALIGN: begin
                if (stop) begin
                    n.mode = sbc_pkg::M_IDLE;
                end else if (align_below_half) begin
                    n.mode = sbc_pkg::M_FORCED;
                    n.fcnt = '0;
                    n.itv  = '0;
                end
            end
            sbc_pkg::M_FORCED: begin
                n.fcnt = s.fcnt + 20'h1;
                if (21'(s.fcnt) >= flen - 21'h1) begin
                    n.fcnt = '0;
                    n.step = step_next(s.step, rev);
                end
                if (stop) begin
                    n.mode = sbc_pkg::M_IDLE;
                end else if (zc && s.itv < flen) begin
                    n.mode = sbc_pkg::M_RUN;
                    n.pend = 1'b0;
                end
            end
            sbc_pkg::M_RUN: begin
                if (s.pend) begin
                    n.dly = s.dly - 21'h1;
                    if (s.dly == 21'h0) begin
                        n.pend = 1'b0;
                        n.ovl  = 1'b0;
                        n.step = step_next(s.step, rev);
                    end
                end
                if (zc) begin
                    prod  = 24'(s.itv) * 24'(3'h4 - lead);
                    n.dly  = prod[23:3];
                    n.pend = 1'b1;
                    n.ovl  = 1'b1;
                end
                if (stop) begin
                    n.mode = sbc_pkg::M_IDLE;
                end else if (prot && zc && s.itv < 21'(MIN_STEP_CYC)) begin
                    n.mode     = sbc_pkg::M_FAULT;
                    n.flt_fast = 1'b1;
                    n.flt_slow = 1'b0;
                    n.rcnt     = '0;
                end else if (prot && s.itv >= flen) begin
                    n.mode     = sbc_pkg::M_FAULT;
                    n.flt_fast = 1'b0;
                    n.flt_slow = 1'b1;
                    n.rcnt     = '0;
                end
            end
            sbc_pkg::M_FAULT: begin
                n.rcnt = s.rcnt + 32'h1;
                n.pend = 1'b0;
                n.ovl  = 1'b0;
                if (s.rcnt >= 32'(RESTART_CYC - 1)) begin
                    n.mode = sbc_pkg::M_IDLE;
                end
            end
        endcase

        active = (n.mode == sbc_pkg::M_ALIGN) || (n.mode == sbc_pkg::M_FORCED)
                 || (n.mode == sbc_pkg::M_RUN);
        n.pwm  = n.raw & active & ~overcurrent_sense;
        b = step_map(n.step);
        if (n.ovl && !s.ctrl[sbc_pkg::CTRL_120]) begin
            b = b | step_map(step_next(n.step, rev));
        end
        // all switches off outside drive modes
        n.br.hs = active ? (b.hs & {3{n.pwm}}) : 3'h0;
        n.br.ls = active ? b.ls : 3'h0;
        n.posout = (phase_polarity[0] & phase_polarity[1])
                   | (phase_polarity[1] & phase_polarity[2])
                   | (phase_polarity[0] & phase_polarity[2]);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            s <= ST_RST;
        else
            s <= n;
    end

    assign prdata       = s.prdata;
    assign pready       = s.pready;
    assign pslverr      = s.pslverr;
    assign bridge       = s.br;
    assign pwm_out      = s.pwm;
    assign position_out = s.posout;
endmodule

/* File: verification/sbc_motor_model.sv */
`timescale 1ns/100ps
module sbc_motor_model (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire sbc_pkg::sbc_bridge_t bridge,
    input  wire logic [15:0]          half_per,
    output logic                      position_sense_pos,
    output logic                      position_sense_neg,
    output logic [2:0]                phase_polarity
);
    logic [15:0] cnt_q;
    // back-emf only moves while a low side conducts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 16'h0;
            position_sense_pos <= 1'b0;
            phase_polarity <= 3'h1;
        end else if (bridge.ls != 3'h0) begin
            cnt_q <= (cnt_q >= half_per) ? 16'h0 : cnt_q + 16'h1;
            if (cnt_q >= half_per) begin
                position_sense_pos <= ~position_sense_pos;
                phase_polarity <= {phase_polarity[1:0], ~phase_polarity[2]};
            end
        end
    end
    assign position_sense_neg = ~position_sense_pos;
endmodule

/* File: verification/sbc_core_assertions.sv */
`timescale 1ns/100ps
module sbc_core_assertions (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire logic [7:0]           paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 align_below_half,
    input wire logic                 position_sense_pos,
    input wire logic                 position_sense_neg,
    input wire logic [2:0]           phase_polarity,
    input wire logic                 overcurrent_sense,
    input wire sbc_pkg::sbc_bridge_t bridge,
    input wire logic                 pwm_out,
    input wire logic                 position_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    AST_APB_ANSWER: assert property (s_setup |=> s_answer)
        else $error("apb answer missing or too long");
    AST_APB_UNMAPPED: assert property ((s_setup and (paddr > 8'h08))
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_APB_MAPPED: assert property ((s_setup and (paddr <= 8'h08 && paddr[1:0] == 2'h0))
        |=> !pslverr)
        else $error("mapped access refused");
    AST_READY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    AST_OC_OFF: assert property (overcurrent_sense |=> !pwm_out && bridge.hs == 3'h0)
        else $error("drive not stopped on overcurrent");
    AST_POS_MAJ: assert property (1 |=> position_out == ($countones($past(phase_polarity)) > 1))
        else $error("position output not majority");
    AST_NO_SHOOT: assert property ((bridge.hs & bridge.ls) == 3'h0)
        else $error("high and low side on in one phase");
    AST_RST_IDLE: assert property ($rose(nrst) |-> {bridge, pwm_out} == 7'h0)
        else $error("drive active right after reset");
endmodule

bind sbc_core sbc_core_assertions chk_u (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .align_below_half(align_below_half), .position_sense_pos(position_sense_pos),
    .position_sense_neg(position_sense_neg), .phase_polarity(phase_polarity),
    .overcurrent_sense(overcurrent_sense), .bridge(bridge), .pwm_out(pwm_out),
    .position_out(position_out)
);

/* File: verification/sensorless_bldc_commutation_control_tb.sv */
`timescale 1ns/100ps
module sensorless_bldc_commutation_control_tb;
    logic                 clk, nrst, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata;
    logic                 abh, ocs, sp, sn, pwm_out, position_out;
    logic [2:0]           phpol;
    logic [15:0]          half_per;
    sbc_pkg::sbc_bridge_t bridge;
    int                   fails, cmp_count;

    sbc_core #(.RESTART_CYC(200), .RAMP_UP_CYC(4), .RAMP_DN_CYC(1), .MIN_STEP_CYC(1000)) dut_u (
        .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .align_below_half(abh), .position_sense_pos(sp), .position_sense_neg(sn),
        .phase_polarity(phpol), .overcurrent_sense(ocs), .bridge(bridge),
        .pwm_out(pwm_out), .position_out(position_out));
    sbc_motor_model motor_u (.clk(clk), .nrst(nrst), .bridge(bridge), .half_per(half_per),
        .position_sense_pos(sp), .position_sense_neg(sn), .phase_polarity(phpol));

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic wait_mode(input logic [2:0] m, output logic [31:0] s);
        int n = 0;
        do begin
            apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
            n++;
        end while (s[2:0] !== m && n < 4000);
        if (s[2:0] !== m) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic pwm_meas(output int hi, output int per);
        int n = 0;
        hi = 0;
        while (pwm_out !== 1'b0 && n < 600) begin @(posedge clk); n++; end
        while (pwm_out !== 1'b1 && n < 600) begin @(posedge clk); n++; end
        while (pwm_out === 1'b1 && n < 600) begin @(posedge clk); n++; hi++; end
        per = hi;
        while (pwm_out !== 1'b1 && n < 600) begin @(posedge clk); n++; per++; end
        if (n >= 600) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic ovl_count(output int c);
        c = 0;
        repeat (4000) begin
            @(posedge clk);
            if ($countones(bridge.ls) > 1 || $countones(bridge.hs) > 1) c++;
        end
    endtask
    task automatic step_pair(output logic [2:0] a, output logic [2:0] b);
        logic [31:0] s;
        int          n = 0;
        apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
        a = s[5:3];
        do begin
            apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
            n++;
        end while (s[5:3] === a && n < 400);
        b = s[5:3];
        if (n >= 400) begin
            fails++;
            tally_and_finish();
        end
    endtask

    task automatic t_regs();
        logic [31:0] r;
        apb(1'b0, sbc_pkg::CTRL_OFS, 32'h0, r);
        chk(r, 32'h3);
        apb(1'b1, sbc_pkg::SPEED_OFS, 32'hffff_ff05, r);
        apb(1'b0, sbc_pkg::SPEED_OFS, 32'h0, r);
        chk(r, 32'h05);
        apb(1'b1, 8'h0c, 32'hff, r);
        chk(32'(last_err), 32'h1);
        apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, r);
        chk(32'(r[2:0]), 32'h0);
    endtask
    task automatic t_start();
        logic [31:0] s;
        apb(1'b1, sbc_pkg::SPEED_OFS, 32'h40, s);
        wait_mode(3'h1, s);
        chk(32'(s[2:0]), 32'h1);
        chk(32'(bridge.ls), 32'h2);
        repeat (300) @(posedge clk);
        apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
        chk(32'(s[14:8]), 32'h40);
        chk(32'(s[2:0]), 32'h1);
        apb(1'b1, sbc_pkg::SPEED_OFS, 32'h20, s);
        repeat (80) @(posedge clk);
        apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
        chk(32'(s[14:8]), 32'h20);
        apb(1'b1, sbc_pkg::SPEED_OFS, 32'h19, s);
        apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
        chk(32'({s[14:8], s[2:0]}), 32'h0);
        apb(1'b1, sbc_pkg::SPEED_OFS, 32'h40, s);
        repeat (20) @(posedge clk);
        apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
        chk(32'(s[14:8] < 7'h10), 32'h1);
        abh <= 1'b1;
        wait_mode(3'h2, s);
        chk(32'(s[2:0]), 32'h2);
    endtask
    task automatic t_run();
        logic [31:0] s;
        int          hi, per;
        logic [2:0]  p;
        wait_mode(3'h3, s);
        chk(32'(s[2:0]), 32'h3);
        apb(1'b1, sbc_pkg::SPEED_OFS, 32'h20, s);
        repeat (20) @(posedge clk);
        pwm_meas(hi, per);
        chk(32'(hi), 32'd64);
        chk(32'(per), 32'd256);
        apb(1'b1, sbc_pkg::CTRL_OFS, 32'h13, s);
        repeat (300) @(posedge clk);
        pwm_meas(hi, per);
        chk(32'(hi), 32'd32);
        chk(32'(per), 32'd128);
        ocs <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({bridge.hs, pwm_out}), 32'h0);
        ocs <= 1'b0;
        p = phpol;
        @(posedge clk);
        chk(32'(position_out), 32'($countones(p) > 1));
    endtask
    task automatic t_fault();
        logic [31:0] s;
        int          c;
        abh <= 1'b0;
        half_per <= 16'd300;
        wait_mode(3'h4, s);
        chk(32'(s[2:0]), 32'h4);
        chk(32'(bridge), 32'h0);
        wait_mode(3'h1, s);
        chk(32'(s[2:0]), 32'h1);
        apb(1'b1, sbc_pkg::CTRL_OFS, 32'h12, s);
        abh <= 1'b1;
        wait_mode(3'h3, s);
        ovl_count(c);
        chk(32'(c), 32'h0);
        apb(1'b1, sbc_pkg::CTRL_OFS, 32'h10, s);
        ovl_count(c);
        chk(32'(c > 0), 32'h1);
        apb(1'b0, sbc_pkg::STATUS_OFS, 32'h0, s);
        chk(32'(s[2:0]), 32'h3);
    endtask
    task automatic t_dir();
        logic [31:0] s;
        logic [2:0]  a, b;
        step_pair(a, b);
        chk(32'(b), (a == 3'h5) ? 32'h0 : 32'(a) + 32'h1);
        apb(1'b1, sbc_pkg::CTRL_OFS, 32'h90, s);
        step_pair(a, b);
        chk(32'(b), (a == 3'h0) ? 32'h5 : 32'(a) - 32'h1);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, abh, ocs} = '0;
        half_per = 16'd2000;
        fails = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_start();
        t_run();
        t_fault();
        t_dir();
        tally_and_finish();
    end
endmodule
